// ===== design/sprc_defines.vh
`ifndef SPRC_DEFINES_VH
`define SPRC_DEFINES_VH
`define SPRC_ADDR_SLEEP 8'h53
`define SPRC_ADDR_MCU 8'h55
`define SPRC_ADDR_GATE 8'h64
`define SPRC_IO_OFFSET 8'h20
`define SPRC_IO_MAX 8'h3F
`define SPRC_SLEEP_MASK 8'h0F
`define SPRC_MCU_MASK 8'h73
`define SPRC_GATE_MASK 8'hEF
`define SPRC_RESET_VAL 8'h00
`define SPRC_BIT_SE 0
`define SPRC_BIT_SMLO 1
`define SPRC_BIT_SMHI 3
`define SPRC_BIT_VECTOR_CHANGE_UNLOCK 0
`define SPRC_BIT_VECTOR_TABLE_SELECT 1
`define SPRC_BIT_PUD 4
`define SPRC_BIT_BROWNOUT_SLEEP_UNLOCK 5
`define SPRC_BIT_BROWNOUT_SLEEP_OFF 6
`define SPRC_BIT_GCONV 0
`define SPRC_BIT_GSPORT 1
`define SPRC_BIT_GSPI 2
`define SPRC_BIT_GTIM1 3
`define SPRC_BIT_GTIM0 5
`define SPRC_BIT_GTIM2 6
`define SPRC_BIT_GTWI 7
`define SPRC_UNLOCK_CYC 3'd4
`define SPRC_BROWNOUT_SLEEP_OFF_CYC 3'd3
`define SPRC_MODE_IDLE 3'b000
`define SPRC_MODE_NOISE 3'b001
`define SPRC_MODE_PDOWN 3'b010
`define SPRC_MODE_PSAVE 3'b011
`define SPRC_MODE_STBY 3'b110
`define SPRC_MODE_XSTBY 3'b111
`define SPRC_STRETCH_DEF 16'h0400
`endif

// ===== design/sprc_timed_unlock.v
`timescale 1ns/100ps
`default_nettype none
module sprc_timed_unlock #(
   parameter [2:0] WIN = 3'd4
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire arm,
   input wire done,
   output wire open_w
);
   reg [2:0] cnt_r;
   reg [2:0] cnt_nxt;
   always @* begin
      cnt_nxt = cnt_r;
      if (arm) begin
         cnt_nxt = WIN;
      end else if (done) begin
         cnt_nxt = 3'd0;
      end else if (cnt_r != 3'd0) begin
         cnt_nxt = cnt_r - 3'd1;
      end
   end
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_r <= 3'd0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   assign open_w = (cnt_r != 3'd0);
endmodule
`default_nettype wire

// ===== design/sprc_reset_stretch.v
`timescale 1ns/100ps
`default_nettype none
module sprc_reset_stretch #(
   parameter [15:0] STRETCH = 16'h0400
) (
   input wire ref_clk,
   input wire src_rst,
   input wire [15:0] fuse_delay,
   output reg hold_r
);
   reg [15:0] cnt_r;
   // Source reset restarts the count on every clocked assertion
   always @(posedge ref_clk) begin
      if (src_rst) begin
         cnt_r <= (fuse_delay == 16'h0000) ? STRETCH : fuse_delay;
         hold_r <= 1'b1;
      end else if (cnt_r != 16'h0000) begin
         cnt_r <= cnt_r - 16'h0001;
         hold_r <= 1'b1;
      end else begin
         hold_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== design/sprc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "sprc_defines.vh"
module sprc_top #(
   parameter [15:0] STRETCH = `SPRC_STRETCH_DEF
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire wr_en,
   input wire rd_en,
   input wire io_space,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire sleep_exec,
   input wire pc_in_boot,
   input wire app_section_boot_lock,
   input wire boot_section_boot_lock,
   input wire timer_two_async_select,
   input wire [15:0] fuse_delay,
   input wire [7:0] pin_direction_bit,
   input wire [7:0] pin_output_bit,
   output reg [7:0] rdata_r,
   output reg rd_hit_r,
   output reg sleep_active_r,
   output reg [2:0] sleep_mode_r,
   output reg brownout_detector_off_r,
   output reg [7:0] pullup_en_r,
   output reg vector_boot_r,
   output reg irq_block_r,
   output reg [7:0] periph_clk_en_r,
   output reg comp_mux_avail_r,
   output reg internal_rst_r
);
   reg [7:0] sleep_control_r;
   reg [7:0] mcu_control_r;
   reg [7:0] peripheral_clock_gate_r;
   reg [1:0] brownout_sleep_off_eff_r;
   reg [2:0] brownout_sleep_off_age_r;
   reg post_vector_table_select_r;
   reg wake_r;
   wire [7:0] eff_addr;
   wire hit_sleep;
   wire hit_mcu;
   wire hit_gate;
   wire wr_mcu;
   wire brownout_sleep_off_open;
   wire vector_change_unlock_open;
   wire brownout_sleep_off_arm;
   wire brownout_sleep_off_set;
   wire vector_table_select_wr;
   wire vector_change_unlock_arm;
   wire hold;
   wire brownout_sleep_off_eff;

   // I/O-instruction form adds the fixed offset back
   assign eff_addr = io_space ? ((addr & `SPRC_IO_MAX) + `SPRC_IO_OFFSET) : addr;
   assign hit_sleep = (eff_addr == `SPRC_ADDR_SLEEP);
   assign hit_mcu = (eff_addr == `SPRC_ADDR_MCU);
   assign hit_gate = (eff_addr == `SPRC_ADDR_GATE);
   assign wr_mcu = wr_en && hit_mcu && !hold;

   function mode_valid;
      input [2:0] m;
      begin
         mode_valid = (m != 3'b100) && (m != 3'b101);
      end
   endfunction

   assign brownout_sleep_off_arm = wr_mcu && wdata[`SPRC_BIT_BROWNOUT_SLEEP_OFF] && wdata[`SPRC_BIT_BROWNOUT_SLEEP_UNLOCK];
   assign brownout_sleep_off_set = wr_mcu && brownout_sleep_off_open && wdata[`SPRC_BIT_BROWNOUT_SLEEP_OFF] && !wdata[`SPRC_BIT_BROWNOUT_SLEEP_UNLOCK];
   assign vector_change_unlock_arm = wr_mcu && wdata[`SPRC_BIT_VECTOR_CHANGE_UNLOCK];
   assign vector_table_select_wr = wr_mcu && vector_change_unlock_open && !wdata[`SPRC_BIT_VECTOR_CHANGE_UNLOCK];

   sprc_timed_unlock #(
      .WIN(`SPRC_UNLOCK_CYC)
   ) u_brownout_sleep_off_unlock (
      .ref_clk(ref_clk),
      .sys_rst(hold),
      .arm(brownout_sleep_off_arm),
      .done(brownout_sleep_off_set),
      .open_w(brownout_sleep_off_open)
   );

   sprc_timed_unlock #(
      .WIN(`SPRC_UNLOCK_CYC)
   ) u_vector_change_unlock_unlock (
      .ref_clk(ref_clk),
      .sys_rst(hold),
      .arm(vector_change_unlock_arm),
      .done(vector_table_select_wr),
      .open_w(vector_change_unlock_open)
   );

   sprc_reset_stretch #(
      .STRETCH(STRETCH)
   ) u_stretch (
      .ref_clk(ref_clk),
      .src_rst(sys_rst),
      .fuse_delay(fuse_delay),
      .hold_r(hold)
   );

   // Registers held in reset for the whole stretched period
   always @(posedge ref_clk) begin
      if (hold) begin
         sleep_control_r <= `SPRC_RESET_VAL;
         peripheral_clock_gate_r <= `SPRC_RESET_VAL;
         mcu_control_r <= `SPRC_RESET_VAL;
         brownout_sleep_off_age_r <= 3'd0;
         brownout_sleep_off_eff_r <= 2'd0;
         post_vector_table_select_r <= 1'b0;
      end else begin
         if (wr_en && hit_sleep) begin
            sleep_control_r <= wdata & `SPRC_SLEEP_MASK;
         end
         if (wr_en && hit_gate) begin
            peripheral_clock_gate_r <= wdata & `SPRC_GATE_MASK;
         end
         if (wr_mcu) begin
            mcu_control_r[`SPRC_BIT_PUD] <= wdata[`SPRC_BIT_PUD];
            mcu_control_r[`SPRC_BIT_BROWNOUT_SLEEP_UNLOCK] <= wdata[`SPRC_BIT_BROWNOUT_SLEEP_UNLOCK];
         end else if (!brownout_sleep_off_open) begin
            mcu_control_r[`SPRC_BIT_BROWNOUT_SLEEP_UNLOCK] <= 1'b0;
         end
         // Set wins over the automatic clear
         if (brownout_sleep_off_set) begin
            mcu_control_r[`SPRC_BIT_BROWNOUT_SLEEP_OFF] <= 1'b1;
            brownout_sleep_off_age_r <= `SPRC_BROWNOUT_SLEEP_OFF_CYC;
         end else if (brownout_sleep_off_age_r == 3'd1) begin
            mcu_control_r[`SPRC_BIT_BROWNOUT_SLEEP_OFF] <= 1'b0;
            brownout_sleep_off_age_r <= 3'd0;
         end else if (brownout_sleep_off_age_r != 3'd0) begin
            brownout_sleep_off_age_r <= brownout_sleep_off_age_r - 3'd1;
         end
         brownout_sleep_off_eff_r <= {brownout_sleep_off_eff_r[0], brownout_sleep_off_set};
         if (vector_table_select_wr) begin
            mcu_control_r[`SPRC_BIT_VECTOR_TABLE_SELECT] <= wdata[`SPRC_BIT_VECTOR_TABLE_SELECT];
         end
         mcu_control_r[`SPRC_BIT_VECTOR_CHANGE_UNLOCK] <= vector_change_unlock_arm || (vector_change_unlock_open && !vector_table_select_wr);
         mcu_control_r[7] <= 1'b0;
         mcu_control_r[3:2] <= 2'b00;
         post_vector_table_select_r <= vector_table_select_wr;
      end
   end

   // Active from the third edge after set until auto-clear
   assign brownout_sleep_off_eff = mcu_control_r[`SPRC_BIT_BROWNOUT_SLEEP_OFF] && (brownout_sleep_off_eff_r == 2'd0) && !brownout_sleep_off_set;

   always @(posedge ref_clk) begin
      if (hold) begin
         rdata_r <= 8'h00;
         rd_hit_r <= 1'b0;
         sleep_active_r <= 1'b0;
         sleep_mode_r <= `SPRC_MODE_IDLE;
         brownout_detector_off_r <= 1'b0;
         vector_boot_r <= 1'b0;
         irq_block_r <= 1'b1;
         periph_clk_en_r <= 8'h00;
         comp_mux_avail_r <= 1'b0;
         wake_r <= 1'b0;
      end else begin
         rd_hit_r <= rd_en && (hit_sleep || hit_mcu || hit_gate);
         if (rd_en && hit_sleep) begin
            rdata_r <= sleep_control_r;
         end else if (rd_en && hit_mcu) begin
            rdata_r <= mcu_control_r & `SPRC_MCU_MASK;
         end else if (rd_en && hit_gate) begin
            rdata_r <= peripheral_clock_gate_r;
         end else begin
            rdata_r <= 8'h00;
         end
         wake_r <= 1'b0;
         // Sleep exits when the core drops sleep_exec level or SE clears; wake_r is never set
         if (sleep_exec && sleep_control_r[`SPRC_BIT_SE] &&
             mode_valid(sleep_control_r[`SPRC_BIT_SMHI:`SPRC_BIT_SMLO])) begin
            sleep_active_r <= 1'b1;
            sleep_mode_r <= sleep_control_r[`SPRC_BIT_SMHI:`SPRC_BIT_SMLO];
            if (!sleep_active_r) begin
               brownout_detector_off_r <= brownout_sleep_off_eff;
            end
         end else begin
            sleep_active_r <= 1'b0;
            brownout_detector_off_r <= 1'b0;
         end
         vector_boot_r <= mcu_control_r[`SPRC_BIT_VECTOR_TABLE_SELECT];
         // Only gates delivery; the core's global enable flag is untouched
         irq_block_r <= vector_change_unlock_arm || vector_change_unlock_open || vector_table_select_wr || post_vector_table_select_r ||
            (mcu_control_r[`SPRC_BIT_VECTOR_TABLE_SELECT] && app_section_boot_lock && !pc_in_boot) ||
            (!mcu_control_r[`SPRC_BIT_VECTOR_TABLE_SELECT] && boot_section_boot_lock && pc_in_boot);
         // Clock gated, not reset, so peripherals resume where they stopped
         periph_clk_en_r <= ~peripheral_clock_gate_r;
         periph_clk_en_r[`SPRC_BIT_GTIM2] <= !peripheral_clock_gate_r[`SPRC_BIT_GTIM2] ||
            timer_two_async_select;
         periph_clk_en_r[4] <= 1'b0;
         comp_mux_avail_r <= !peripheral_clock_gate_r[`SPRC_BIT_GCONV];
      end
   end

   // Pull-ups drop through the asynchronous reset of the register on the source reset, no clock needed
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pullup_en_r <= 8'h00;
      end else if (hold || mcu_control_r[`SPRC_BIT_PUD]) begin
         pullup_en_r <= 8'h00;
      end else begin
         pullup_en_r <= ~pin_direction_bit & pin_output_bit;
      end
   end

   always @(posedge ref_clk) begin
      internal_rst_r <= hold;
   end
endmodule
`default_nettype wire

// ===== test/sprc_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module sprc_top_props (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic io_space,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic sleep_exec,
   input wire logic app_section_boot_lock,
   input wire logic boot_section_boot_lock,
   input wire logic [7:0] rdata_r,
   input wire logic rd_hit_r,
   input wire logic sleep_active_r,
   input wire logic [2:0] sleep_mode_r,
   input wire logic [7:0] pullup_en_r,
   input wire logic irq_block_r,
   input wire logic [7:0] periph_clk_en_r,
   input wire logic comp_mux_avail_r,
   input wire logic internal_rst_r
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_vector_change_unlock;
      wr_en && !internal_rst_r && wdata == 8'h01 && (io_space ? addr == 8'h35 : addr == 8'h55);
   endsequence
   sequence s_quiet;
      !wr_en && !app_section_boot_lock && !boot_section_boot_lock;
   endsequence
   property p_pull_rst;
      disable iff (1'b0) sys_rst |-> pullup_en_r == 8'h00;
   endproperty
   a_pull_rst: assert property (p_pull_rst) else $error("pull-ups live in reset");
   property p_rst_hold;
      disable iff (1'b0) sys_rst |-> ##2 internal_rst_r;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("internal reset low");
   property p_rd_idle;
      !$past(rd_en) |-> rdata_r == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_unmapped;
      rd_en && !io_space && addr == 8'h60 |=> !rd_hit_r && rdata_r == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read hit");
   property p_resv;
      rd_en && !io_space && addr == 8'h53 |=> rdata_r[7:4] == 4'h0;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_gate;
      !periph_clk_en_r[4] && comp_mux_avail_r == periph_clk_en_r[0];
   endproperty
   a_gate: assert property (p_gate) else $error("converter gate mismatch");
   property p_sleep_cause;
      sleep_active_r |-> $past(sleep_exec);
   endproperty
   a_sleep_cause: assert property (p_sleep_cause) else $error("sleep without instruction");
   property p_mode;
      sleep_active_r |-> sleep_mode_r != 3'b100 && sleep_mode_r != 3'b101;
   endproperty
   a_mode: assert property (p_mode) else $error("reserved mode slept");
   property p_mask_on;
      s_vector_change_unlock |=> irq_block_r;
   endproperty
   a_mask_on: assert property (p_mask_on) else $error("no mask on unlock");
   property p_mask_len;
      s_vector_change_unlock ##1 s_quiet [*5] |=> !irq_block_r;
   endproperty
   a_mask_len: assert property (p_mask_len) else $error("mask too long");
endmodule
`default_nettype wire

// ===== test/sprc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module sprc_core_model (
   input wire logic ref_clk,
   input wire logic [7:0] rdata_r,
   output var logic wr_en = 1'b0,
   output var logic rd_en = 1'b0,
   output var logic io_space = 1'b0,
   output var logic [7:0] addr = 8'h00,
   output var logic [7:0] wdata = 8'h00,
   output var logic sleep_exec = 1'b0
);
   // One idle cycle between accesses keeps timed pairs inside four cycles
   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      @(negedge ref_clk);
      {wr_en, io_space, addr, wdata} = {1'b1, io, io ? a - 8'h20 : a, d};
      @(negedge ref_clk);
      {wr_en, addr, wdata} = {1'b0, ~addr, ~wdata};
   endtask
   task automatic rd(input logic [7:0] a, input logic io, output logic [7:0] d);
      @(negedge ref_clk);
      {rd_en, io_space, addr} = {1'b1, io, io ? a - 8'h20 : a};
      @(negedge ref_clk);
      d = rdata_r;
      {rd_en, addr} = {1'b0, ~addr};
   endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0, sys_rst = 1'b0, pcb = 1'b0, alk = 1'b0, blk = 1'b0, t2a = 1'b0;
   logic [7:0] dir = 8'h00, pout = 8'h00, d, g;
   logic [31:0] seed = 32'hfc270d5c;
   int err_count = 0, checks = 0, i, k;
   wire wr_en, rd_en, io_space, sleep_exec, rd_hit_r, slp, brownout_detector, vb, irqb, cmux, irst;
   wire [7:0] addr, wdata, rdata_r, pull, clken;
   wire [2:0] smode;
   always #50 ref_clk = ~ref_clk;
   sprc_core_model u_sprc_core_model (.ref_clk, .rdata_r, .wr_en, .rd_en, .io_space, .addr, .wdata, .sleep_exec);
   sprc_top #(.STRETCH(16'h0004)) u_sprc_top (.ref_clk, .sys_rst, .wr_en, .rd_en, .io_space, .addr, .wdata,
      .sleep_exec, .pc_in_boot(pcb), .app_section_boot_lock(alk), .boot_section_boot_lock(blk),
      .timer_two_async_select(t2a), .fuse_delay(16'h0004), .pin_direction_bit(dir), .pin_output_bit(pout),
      .rdata_r, .rd_hit_r, .sleep_active_r(slp), .sleep_mode_r(smode), .brownout_detector_off_r(brownout_detector),
      .pullup_en_r(pull), .vector_boot_r(vb), .irq_block_r(irqb), .periph_clk_en_r(clken),
      .comp_mux_avail_r(cmux), .internal_rst_r(irst));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic boot(input int n);
      repeat (n) @(negedge ref_clk);
      sys_rst = 1'b0;
      for (k = 0; k < 40 && irst !== 1'b0; k++) @(negedge ref_clk);
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   initial begin
      #500000;
      err_count++;
      close_out;
   end
   initial begin
      // Clean rising edge so the asynchronous pull-up clear fires before the first clock
      #1 sys_rst = 1'b1;
      boot(20);
      for (i = 0; i < 3; i++) begin
         u_sprc_core_model.rd(i == 0 ? 8'h53 : i == 1 ? 8'h55 : 8'h64, i[0], d);
         cmp(d, 8'h00);
      end
      u_sprc_core_model.rd(8'h60, 1'b0, d);
      cmp({d[6:0], rd_hit_r}, 8'h00);
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         g = i == 0 ? 8'hFF : i == 1 ? 8'h00 : seed[7:0];
         t2a = seed[8];
         // Gate register sits above the I/O window, data space only
         u_sprc_core_model.wr(8'h64, 1'b0, g);
         u_sprc_core_model.rd(8'h64, 1'b0, d);
         cmp(d, g & 8'hEF);
         cmp(clken, (~g & 8'hEF) | {1'b0, t2a, 6'h00});
         cmp({7'h00, cmux}, {7'h00, ~g[0]});
      end
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         dir = seed[7:0];
         pout = seed[15:8];
         u_sprc_core_model.wr(8'h55, 1'b0, {3'b000, seed[16], 4'h0});
         tick(2);
         cmp(pull, ~dir & pout & {8{~seed[16]}});
      end
      g = 8'h00;
      for (i = 0; i < 16; i++) begin
         u_sprc_core_model.wr(8'h53, i[0], {4'h0, i[3:0]});
         // Mode output only follows the field when a sleep is taken
         if (i[0] && i[3:2] != 2'b10) g[2:0] = i[3:1];
         force_sleep(1'b1);
         cmp({4'h0, slp, smode}, {4'h0, i[0] & (i[3:2] != 2'b10), g[2:0]});
         force_sleep(1'b0);
         u_sprc_core_model.wr(8'h53, 1'b0, 8'h00);
      end
      u_sprc_core_model.wr(8'h53, 1'b0, 8'h05);
      for (i = 0; i < 2; i++) begin
         if (i == 1) u_sprc_core_model.wr(8'h55, 1'b0, 8'h60);
         u_sprc_core_model.wr(8'h55, 1'b0, 8'h40);
         g = 8'h00;
         // Sleep must land in the one cycle the sleep-off bit is effective
         tick(2);
         u_sprc_core_model.sleep_exec = 1'b1;
         repeat (6) begin
            @(negedge ref_clk);
            g[0] = g[0] | brownout_detector;
         end
         u_sprc_core_model.sleep_exec = 1'b0;
         cmp(g, i[7:0]);
         u_sprc_core_model.rd(8'h55, 1'b0, d);
         cmp(d & 8'h60, 8'h00);
      end
      u_sprc_core_model.wr(8'h53, 1'b0, 8'h00);
      u_sprc_core_model.wr(8'h55, 1'b1, 8'h01);
      cmp({7'h00, irqb}, 8'h01);
      u_sprc_core_model.wr(8'h55, 1'b1, 8'h02);
      tick(2);
      cmp({7'h00, vb}, 8'h01);
      u_sprc_core_model.wr(8'h55, 1'b0, 8'h00);
      tick(2);
      cmp({6'h00, vb, irqb}, 8'h02);
      u_sprc_core_model.wr(8'h55, 1'b0, 8'h01);
      tick(6);
      u_sprc_core_model.rd(8'h55, 1'b0, d);
      cmp({6'h00, d[0], irqb}, 8'h00);
      alk = 1'b1;
      tick(2);
      cmp({7'h00, irqb}, 8'h01);
      pcb = 1'b1;
      tick(2);
      cmp({7'h00, irqb}, 8'h00);
      {alk, pcb, dir, pout} = {2'b00, 8'h00, 8'hFF};
      tick(2);
      sys_rst = 1'b1;
      #10;
      cmp(pull, 8'h00);
      boot(2);
      cmp({7'h00, vb}, 8'h00);
      close_out;
   end
   task automatic force_sleep(input logic v);
      u_sprc_core_model.sleep_exec = v;
      tick(3);
   endtask
endmodule
bind sprc_top sprc_top_props u_sprc_top_props (.ref_clk, .sys_rst, .wr_en, .rd_en, .io_space, .addr, .wdata,
   .sleep_exec, .app_section_boot_lock, .boot_section_boot_lock, .rdata_r, .rd_hit_r, .sleep_active_r,
   .sleep_mode_r, .pullup_en_r, .irq_block_r, .periph_clk_en_r, .comp_mux_avail_r, .internal_rst_r);
`default_nettype wire
